/* design/tsref_regs.v */
// register bank for the temperature sensor and band gap reference
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tsref_defs.vh"

module tsref_regs #(
  parameter [8:0] CAL_DEFAULT = 9'h000
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // factory calibration load
  input  wire        cal_load,
  input  wire [8:0]  cal_value,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // analog controls
  output reg         chop_enable,
  output reg         ref_power_down,
  output reg         ref_pin_enable,
  output reg  [8:0]  temp_calibration_reference
);

  // ****************************************************
  // register selects
  // ****************************************************
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_REF  = 2'h1;
  localparam [1:0] SEL_TSC  = 2'h2;
  localparam [1:0] SEL_CAL  = 2'h3;

  // ****************************************************
  // address decode
  // ****************************************************
  // low two address bits are ignored; unmapped words select none
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      case ({addr[31:2], 2'b00})
        `TSREF_ADDR_REFERENCE_CONTROL:   reg_sel = SEL_REF;
        `TSREF_ADDR_TEMP_SENSOR_CONTROL: reg_sel = SEL_TSC;
        `TSREF_ADDR_TEMP_CALIBRATION:    reg_sel = SEL_CAL;
        default:                         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // unmapped words answer with a slave error and change nothing
  function [1:0] sel_resp;
    input [1:0] sel;
    begin
      if (sel == SEL_NONE) begin
        sel_resp = `TSREF_RESP_SLVERR;
      end else begin
        sel_resp = `TSREF_RESP_OKAY;
      end
    end
  endfunction

  // ****************************************************
  // write channel
  // ****************************************************
  reg        aw_held;
  reg        w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held | aw_take;
  wire have_w  = w_held | w_take;
  wire do_write = have_aw & have_w & ~s_axi_bvalid;
  wire [31:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire [1:0]  wr_sel  = reg_sel(wr_addr);
  wire        wr_lane0 = wr_strb[0];
  wire        wr_lane1 = wr_strb[1];

  // capture each channel's payload on its own handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 32'h00000000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // write handshake; readies stay low while a response waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TSREF_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
    end else begin
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= sel_resp(wr_sel);
      end else begin
        aw_held <= have_aw;
        w_held  <= have_w;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      // accept each channel only while nothing of it is pending
      s_axi_awready <= ~have_aw & ~s_axi_awready;
      s_axi_wready  <= ~have_w & ~s_axi_wready;
      if (do_write || s_axi_bvalid) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end
    end
  end

  // ****************************************************
  // write decode
  // ****************************************************
  // a hit lasts exactly the cycle in which the write is applied
  wire wr_ref_hit = do_write & (wr_sel == SEL_REF);
  wire wr_tsc_hit = do_write & (wr_sel == SEL_TSC);
  wire wr_cal_hit = do_write & (wr_sel == SEL_CAL);

  // ****************************************************
  // control registers
  // ****************************************************
  reg       next_chop_enable;
  reg       next_ref_power_down;
  reg       next_ref_pin_enable;
  reg [8:0] next_temp_calibration_reference;

  always @* begin
    next_chop_enable = chop_enable;
    if (wr_tsc_hit && wr_lane0) begin
      next_chop_enable = wr_data[`TSREF_TSC_CHOP_BIT];
    end
  end

  always @* begin
    next_ref_power_down = ref_power_down;
    next_ref_pin_enable = ref_pin_enable;
    if (wr_ref_hit && wr_lane0) begin
      next_ref_power_down = wr_data[`TSREF_REF_PDOWN_BIT];
      next_ref_pin_enable = wr_data[`TSREF_REF_PIN_BIT];
    end
  end

  // only the mapped bits are stored, the rest is dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      chop_enable    <= `TSREF_TSC_RESET;
      {ref_power_down, ref_pin_enable} <= `TSREF_REF_RESET;
    end else begin
      chop_enable    <= next_chop_enable;
      ref_power_down <= next_ref_power_down;
      ref_pin_enable <= next_ref_pin_enable;
    end
  end

  // ****************************************************
  // calibration register
  // ****************************************************
  // bus reset loads CAL_DEFAULT into calibration through cal_init; factory load sets it
  reg cal_init;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cal_init <= 1'b0;
    end else begin
      cal_init <= 1'b1;
    end
  end

  // a factory load wins over a bus write in the same cycle
  always @* begin
    next_temp_calibration_reference = temp_calibration_reference;
    if (cal_load) begin
      next_temp_calibration_reference = cal_value;
    end else if (wr_cal_hit) begin
      if (wr_lane0) begin
        next_temp_calibration_reference[`TSREF_CAL_MAG_MSB:0] = wr_data[7:0];
      end
      if (wr_lane1) begin
        next_temp_calibration_reference[`TSREF_CAL_SIGN_BIT] = wr_data[8];
      end
    end
  end

  // the default is loaded again on the first edge after reset is gone; updates start on the second
  always @(posedge aclk) begin
    if (!cal_init) begin
      temp_calibration_reference <= CAL_DEFAULT;
    end else begin
      temp_calibration_reference <= next_temp_calibration_reference;
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  wire [1:0]  rd_sel  = reg_sel(s_axi_araddr);
  wire        rd_take = s_axi_arvalid & s_axi_arready;
  wire [31:0] ref_word = {30'h00000000, ref_power_down, ref_pin_enable};
  wire [31:0] tsc_word = {31'h00000000, chop_enable};
  wire [31:0] cal_word = {23'h000000, temp_calibration_reference};

  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    case (rd_sel)
      SEL_REF: rd_word = ref_word;
      SEL_TSC: rd_word = tsc_word;
      SEL_CAL: rd_word = cal_word;
      default: rd_word = 32'h00000000;
    endcase
  end

  // arready pulses once and stays low while a read answer waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    end
  end

  // read answer holds until the master takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TSREF_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= sel_resp(rd_sel);
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tsref_regs
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the sensor and reference register bank
`timescale 1ns/1ps
`default_nettype none
`include "tsref_defs.vh"
module tb;
  localparam [31:0] RC = `TSREF_ADDR_REFERENCE_CONTROL;
  localparam [31:0] TC = `TSREF_ADDR_TEMP_SENSOR_CONTROL;
  localparam [31:0] CA = `TSREF_ADDR_TEMP_CALIBRATION;
  logic aclk = 0, aresetn = 0, cal_load = 0;
  logic [8:0] cal_value = 9'h000;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic chop_enable, ref_power_down, ref_pin_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [8:0] temp_calibration_reference;
  int fail_count = 0, samples_checked = 0;
  tsref_regs tsref_regs_inst (.*);
  always #2.5 aclk = ~aclk;
  task automatic chk(input string n, input [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input [31:0] a, v, input [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic t_reset;
    rd(RC); chk("refctl", 0, d);
    rd(TC); chk("tsctl", 0, d);
    rd(CA); chk("cal", 0, d);
  endtask
  task automatic t_chop;
    wr(TC, 32'hFFFFFFFF, 4'hF);
    chk("bresp", `TSREF_RESP_OKAY, r);
    rd(TC); chk("tsctl", 1, d);
    chk("rresp", `TSREF_RESP_OKAY, r);
    chk("chop", 1, chop_enable);
    wr(TC, 32'h0, 4'hF);
    chk("chop", 0, chop_enable);
  endtask
  task automatic t_ref;
    for (int i = 0; i < 4; i++) begin
      wr(RC, 32'hFC | i, 4'hF);
      rd(RC); chk("refctl", i, d);
      chk("pdown", i / 2, ref_power_down);
      chk("pin", i % 2, ref_pin_enable);
    end
  endtask
  task automatic t_cal;
    @(posedge aclk);
    cal_load <= 1;
    cal_value <= 9'h1A5;
    @(posedge aclk);
    cal_load <= 0;
    @(posedge aclk);
    chk("calout", 9'h1A5, temp_calibration_reference);
    wr(CA, 32'hFFFFFE5A, 4'h1);
    rd(CA); chk("cal", 9'h15A, d);
    wr(CA, 32'h0, 4'h2);
    rd(CA); chk("cal", 9'h05A, d);
  endtask
  task automatic t_soft;
    int code, mv, avg;
    wr(TC, 32'h1, 4'hF); chk("chop", 1, chop_enable);
    rd(CA); avg = d;
    rd(CA); avg = (avg + d) / 2;
    code = avg[8] ? 2292 - avg[7:0] : 2292 + avg[7:0];
    chk("code", 2382, code);
    mv = code * 2500 / 4096;
    chk("millivolts", 1453, mv);
    wr(RC, 32'h2, 4'hF); chk("pdown", 1, ref_power_down);
    wr(RC, 32'h0, 4'hF); chk("pdown", 0, ref_power_down);
    chk("pin", 0, ref_pin_enable);
  endtask
  task automatic t_bad;
    wr(32'hFFFF0000, 32'hFF, 4'hF);
    chk("bresp", `TSREF_RESP_SLVERR, r);
    rd(32'hFFFF0000);
    chk("rresp", `TSREF_RESP_SLVERR, r);
    chk("rdata", 0, d);
  endtask
  task print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_chop();
    t_ref();
    t_cal();
    t_soft();
    t_bad();
    print_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire

/* dv/tsref_props.sv */
// assertions on the sensor and reference register bank
`timescale 1ns/1ps
`default_nettype none
module tsref_props (
  input wire logic        aclk, aresetn, cal_load,
  input wire logic        s_axi_bvalid, s_axi_rvalid,
  input wire logic        chop_enable, ref_power_down, ref_pin_enable,
  input wire logic [8:0]  cal_value, temp_calibration_reference,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a write completes when its response appears
  sequence wr_done;
    $rose(s_axi_bvalid);
  endsequence
  chk_chop_write: assert property ($changed(chop_enable) |-> wr_done)
    else $error("chop changed without a write");
  chk_reset_values: assert property (disable iff (1'b0) !aresetn |=>
    !chop_enable && !ref_power_down && !ref_pin_enable)
    else $error("control outputs not cleared by reset");
  chk_cal_load: assert property (cal_load |=>
    temp_calibration_reference == $past(cal_value))
    else $error("calibration load not taken");
  chk_pdown_write: assert property ($changed(ref_power_down) |-> wr_done)
    else $error("power down changed without a write");
  chk_pin_write: assert property ($changed(ref_pin_enable) |-> wr_done)
    else $error("pin enable changed without a write");
  chk_rdata_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:9] == 23'h0)
    else $error("upper read data not zero");
endmodule // tsref_props
bind tsref_regs tsref_props tsref_props_inst (.*);
`default_nettype wire

/* include/tsref_defs.vh */
// register map, field positions and reset values of the sensor/reference bank
`ifndef TSREF_DEFS_VH
`define TSREF_DEFS_VH

// byte addresses (printed offsets are multiples of four)
`define TSREF_ADDR_REFERENCE_CONTROL   32'hFFFF048C
`define TSREF_ADDR_TEMP_SENSOR_CONTROL 32'hFFFF0544
`define TSREF_ADDR_TEMP_CALIBRATION    32'hFFFF0548

// field positions
`define TSREF_TSC_CHOP_BIT   0
`define TSREF_REF_PIN_BIT    0
`define TSREF_REF_PDOWN_BIT  1
`define TSREF_CAL_SIGN_BIT   8
`define TSREF_CAL_MAG_MSB    7

// reset values
`define TSREF_TSC_RESET      1'h0
`define TSREF_REF_RESET      2'h0

// axi response codes
`define TSREF_RESP_OKAY      2'h0
`define TSREF_RESP_SLVERR    2'h2

`endif
